//--- hw/rcalu_defines.vh
/*
  Constants for the 8-bit core datapath: instruction fields and codes,
  register file locations of the core registers, status bits, phases.
  Assumes inclusion by bare name from the core file only.
*/
`ifndef RCALU_DEFINES_VH
`define RCALU_DEFINES_VH

// register file locations held inside the core
`define RCALU_ADDR_INDF 5'h00
`define RCALU_ADDR_PCL 5'h02
`define RCALU_ADDR_STATUS 5'h03
`define RCALU_ADDR_FSR 5'h04

// status bits
`define RCALU_BIT_C 0
`define RCALU_BIT_DC 1
`define RCALU_BIT_Z 2
`define RCALU_PAGE 6:5
`define RCALU_STATUS_RST 8'h18

// instruction fields
`define RCALU_F_FIELD 4:0
`define RCALU_K8 7:0
`define RCALU_K9 8:0
`define RCALU_BIT_SEL 7:5
`define RCALU_OP_FIELD 9:6
`define RCALU_CLS_FIELD 11:10
`define RCALU_LIT_SEL 9:8
`define RCALU_PFX4 11:8
`define RCALU_PFX3 11:9
`define RCALU_D_BIT 5
`define RCALU_BITOP_SET 8
`define RCALU_BITOP_TEST 9

// instruction classes and prefixes
`define RCALU_CLS_BYTE 2'h0
`define RCALU_CLS_BIT 2'h1
`define RCALU_CLS_LIT 2'h3
`define RCALU_PFX_RETLW 4'h8
`define RCALU_PFX_CALL 4'h9
`define RCALU_PFX_GOTO 3'h5
`define RCALU_INSN_NOP 12'h000

// arithmetic unit operations
`define RCALU_OP_MOVW 4'h0
`define RCALU_OP_CLR 4'h1
`define RCALU_OP_SUB 4'h2
`define RCALU_OP_DEC 4'h3
`define RCALU_OP_IOR 4'h4
`define RCALU_OP_AND 4'h5
`define RCALU_OP_XOR 4'h6
`define RCALU_OP_ADD 4'h7
`define RCALU_OP_MOV 4'h8
`define RCALU_OP_COM 4'h9
`define RCALU_OP_INC 4'ha
`define RCALU_OP_DECSZ 4'hb
`define RCALU_OP_ROTR 4'hc
`define RCALU_OP_ROTL 4'hd
`define RCALU_OP_SWAP 4'he
`define RCALU_OP_INCSZ 4'hf
`define RCALU_LIT_BASE 4'h3

// one-hot phase codes
`define RCALU_PH_ONE 4'h1
`define RCALU_PH_TWO 4'h2
`define RCALU_PH_THREE 4'h4
`define RCALU_PH_FOUR 4'h8

`endif

//--- hw/rcalu_core.v
/*
  Core of a small 8-bit microcontroller: two-stage fetch/execute,
  four-phase instruction cycle, accumulator, status flags, two-entry
  return stack, program counter, status and indirect pointer mapped
  into the data register file.
  Assumes program memory answering pm_data_i combinationally from
  pm_addr_o, and a register file answering rf_rdata_i combinationally
  from rf_addr_o; rc_mode_i is a static configuration level.
*/
`include "rcalu_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module rcalu_core #(
  parameter PC_W = 11
) (
  input wire clock_i,                    // core clock
  input wire rst_i,                      // async reset, active high
  input wire master_clear_n_i,           // reset pin, active low
  input wire rc_mode_i,                  // rc oscillator configuration
  output wire [PC_W-1:0] pm_addr_o,      // program memory address
  input wire [11:0] pm_data_i,           // program memory word
  output wire [4:0] rf_addr_o,           // register file address
  output wire rf_rd_o,                   // register file read strobe
  input wire [7:0] rf_rdata_i,           // register file read data
  output wire rf_wr_o,                   // register file write strobe
  output wire [7:0] rf_wdata_o,          // register file write data
  output wire [7:0] acc_o,               // accumulator
  output wire [7:0] status_o,            // status register
  output wire [3:0] phase_o,             // one-hot instruction phase
  output wire quarter_rate_clock_out_o   // quarter rate clock
);

  localparam [PC_W-1:0] PC_TOP = {PC_W{1'b1}};
  localparam [PC_W-1:0] PC_ONE = {{(PC_W-1){1'b0}}, 1'b1};

  // flags in bits 9:8 (carry, half carry), result in 7:0
  function [9:0] rcalu_alu;
    input [3:0] op;
    input [7:0] w;
    input [7:0] f;
    input cin;
    reg [8:0] s;
    reg [4:0] n;
    begin
      s = {1'b0, f} + {1'b0, ~w} + 9'h001;
      n = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
      case (op)
        `RCALU_OP_MOVW: rcalu_alu = {cin, 1'b0, w};
        `RCALU_OP_CLR: rcalu_alu = {cin, 1'b0, 8'h00};
        `RCALU_OP_SUB: rcalu_alu = {s[8], n[4], s[7:0]};
        `RCALU_OP_DEC, `RCALU_OP_DECSZ: rcalu_alu = {cin, 1'b0, f - 8'h01};
        `RCALU_OP_IOR: rcalu_alu = {cin, 1'b0, f | w};
        `RCALU_OP_AND: rcalu_alu = {cin, 1'b0, f & w};
        `RCALU_OP_XOR: rcalu_alu = {cin, 1'b0, f ^ w};
        `RCALU_OP_ADD: begin
          s = {1'b0, f} + {1'b0, w};
          n = {1'b0, f[3:0]} + {1'b0, w[3:0]};
          rcalu_alu = {s[8], n[4], s[7:0]};
        end
        `RCALU_OP_COM: rcalu_alu = {cin, 1'b0, ~f};
        `RCALU_OP_INC, `RCALU_OP_INCSZ: rcalu_alu = {cin, 1'b0, f + 8'h01};
        `RCALU_OP_ROTR: rcalu_alu = {f[0], 1'b0, cin, f[7:1]};
        `RCALU_OP_ROTL: rcalu_alu = {f[7], 1'b0, f[6:0], cin};
        `RCALU_OP_SWAP: rcalu_alu = {cin, 1'b0, f[3:0], f[7:4]};
        default: rcalu_alu = {cin, 1'b0, f};
      endcase
    end
  endfunction

  // indirect access goes through the pointer
  function [4:0] rcalu_eff;
    input [4:0] f;
    input [7:0] ptr;
    begin
      rcalu_eff = (f == `RCALU_ADDR_INDF) ? ptr[4:0] : f;
    end
  endfunction

  // all-zero test shared by zero flag and skip decode
  function rcalu_zero;
    input [7:0] v;
    begin
      rcalu_zero = (v == 8'h00);
    end
  endfunction

  reg [2:0] master_clear_n_s_q;
  reg master_clear_n_f_q;
  reg [3:0] phase_q;
  reg [PC_W-1:0] pc_q;
  reg [PC_W-1:0] stk0_q;
  reg [PC_W-1:0] stk1_q;
  reg [11:0] fetch_q;
  reg [11:0] ir_q;
  reg flush_q;
  reg hold_q;
  reg [4:0] addr_q;
  reg [7:0] opnd_q;
  reg [7:0] w_q;
  reg [7:0] st_q;
  reg [7:0] fsr_q;
  reg [7:0] wdata_q;
  reg quarter_rate_clock_out_q;

  // pin filter: level taken once second and third stages agree
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      master_clear_n_s_q <= 3'h7;
      master_clear_n_f_q <= 1'b1;
    end else begin
      master_clear_n_s_q <= {master_clear_n_s_q[1:0], master_clear_n_i};
      if (master_clear_n_s_q[1] == master_clear_n_s_q[2])
        master_clear_n_f_q <= master_clear_n_s_q[2];
    end
  end

  // decode of the executing word
  wire [1:0] cls = ir_q[`RCALU_CLS_FIELD];
  wire [3:0] op = ir_q[`RCALU_OP_FIELD];
  wire is_byte = cls == `RCALU_CLS_BYTE;
  wire is_bit = cls == `RCALU_CLS_BIT;
  wire is_lit = cls == `RCALU_CLS_LIT;
  wire is_retlw = ir_q[`RCALU_PFX4] == `RCALU_PFX_RETLW;
  wire is_call = ir_q[`RCALU_PFX4] == `RCALU_PFX_CALL;
  wire is_goto = ir_q[`RCALU_PFX3] == `RCALU_PFX_GOTO;
  wire lit_mov = ir_q[`RCALU_LIT_SEL] == 2'h0;
  wire [3:0] lit_op = lit_mov ? `RCALU_OP_MOV : (`RCALU_LIT_BASE + {2'h0, ir_q[`RCALU_LIT_SEL]});
  wire [3:0] aop = is_lit ? lit_op : (is_retlw ? `RCALU_OP_MOV : op);
  wire [7:0] b_opnd = (is_lit | is_retlw) ? ir_q[`RCALU_K8] : opnd_q;
  wire [9:0] alu = rcalu_alu(aop, w_q, b_opnd, st_q[`RCALU_BIT_C]);

  wire [7:0] bmask = 8'h01 << ir_q[`RCALU_BIT_SEL];
  wire [7:0] bit_res = ir_q[`RCALU_BITOP_SET] ? (opnd_q | bmask) : (opnd_q & ~bmask);
  wire bit_val = |(opnd_q & bmask);
  wire [7:0] result = is_bit ? bit_res : alu[7:0];

  wire d_f = ir_q[`RCALU_D_BIT];
  wire wr_f = (is_byte & d_f) | (is_bit & ~ir_q[`RCALU_BITOP_TEST]);
  wire wr_w = (is_byte & ~d_f & (op != `RCALU_OP_MOVW)) | is_lit | is_retlw;
  wire flag_en = is_byte | (is_lit & ~lit_mov);
  wire z_aff = flag_en & (aop >= `RCALU_OP_CLR) & (aop <= `RCALU_OP_INC);
  wire c_aff = flag_en & ((aop == `RCALU_OP_SUB) | (aop == `RCALU_OP_ADD) |
                          (aop == `RCALU_OP_ROTR) | (aop == `RCALU_OP_ROTL));
  wire dc_aff = flag_en & ((aop == `RCALU_OP_SUB) | (aop == `RCALU_OP_ADD));

  wire skip = (is_bit & ir_q[`RCALU_BITOP_TEST] & (bit_val == ir_q[`RCALU_BITOP_SET])) |
              (is_byte & ((op == `RCALU_OP_DECSZ) | (op == `RCALU_OP_INCSZ)) & rcalu_zero(alu[7:0]));

  wire int_pcl = addr_q == `RCALU_ADDR_PCL;
  wire int_st = addr_q == `RCALU_ADDR_STATUS;
  wire int_fsr = addr_q == `RCALU_ADDR_FSR;
  wire ext = ~(int_pcl | int_st | int_fsr);
  wire pcl_wr = wr_f & int_pcl;
  wire branch = is_goto | is_call | is_retlw | pcl_wr;

  // phase decodes for strobes and clock out
  wire ph_two = phase_q == `RCALU_PH_TWO;
  wire ph_three = phase_q == `RCALU_PH_THREE;
  wire ph_four = phase_q == `RCALU_PH_FOUR;

  // targets built at full width; upper page bits drop on small variants
  wire [10:0] tgt_goto = {st_q[`RCALU_PAGE], ir_q[`RCALU_K9]};
  wire [10:0] tgt_call = {st_q[`RCALU_PAGE], 1'b0, ir_q[`RCALU_K8]};
  wire [10:0] tgt_pcl = {st_q[`RCALU_PAGE], 1'b0, result};

  reg [7:0] rd_mux;
  always @* begin
    if (int_pcl)
      rd_mux = pc_q[7:0];
    else if (int_st)
      rd_mux = st_q;
    else if (int_fsr)
      rd_mux = fsr_q;
    else
      rd_mux = rf_rdata_i;
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q <= `RCALU_PH_ONE;
      pc_q <= PC_TOP;
      stk0_q <= {PC_W{1'b0}};
      stk1_q <= {PC_W{1'b0}};
      fetch_q <= `RCALU_INSN_NOP;
      ir_q <= `RCALU_INSN_NOP;
      flush_q <= 1'b1;
      hold_q <= 1'b1;
      addr_q <= 5'h00;
      opnd_q <= 8'h00;
      w_q <= 8'h00;
      st_q <= `RCALU_STATUS_RST;
      fsr_q <= 8'h00;
      wdata_q <= 8'h00;
      quarter_rate_clock_out_q <= 1'b0;
    end else if (!master_clear_n_f_q) begin
      phase_q <= `RCALU_PH_ONE;
      pc_q <= PC_TOP;
      stk0_q <= {PC_W{1'b0}};
      stk1_q <= {PC_W{1'b0}};
      fetch_q <= `RCALU_INSN_NOP;
      ir_q <= `RCALU_INSN_NOP;
      flush_q <= 1'b1;
      hold_q <= 1'b1;
      addr_q <= 5'h00;
      opnd_q <= 8'h00;
      w_q <= 8'h00;
      st_q <= `RCALU_STATUS_RST;
      fsr_q <= 8'h00;
      wdata_q <= 8'h00;
      quarter_rate_clock_out_q <= 1'b0;
    end else begin
      phase_q <= {phase_q[2:0], phase_q[3]};
      quarter_rate_clock_out_q <= rc_mode_i & (ph_two | ph_three);
      case (phase_q)
        `RCALU_PH_ONE: begin
          ir_q <= flush_q ? `RCALU_INSN_NOP : fetch_q;
          addr_q <= rcalu_eff(fetch_q[`RCALU_F_FIELD], fsr_q);
          flush_q <= 1'b0;
          hold_q <= 1'b0;
          if (!hold_q)
            pc_q <= pc_q + PC_ONE;
        end
        `RCALU_PH_TWO: begin
          opnd_q <= rd_mux;
        end
        `RCALU_PH_THREE: begin
          wdata_q <= result;
        end
        `RCALU_PH_FOUR: begin
          fetch_q <= pm_data_i;
          if (wr_w)
            w_q <= result;
          if (wr_f & int_fsr)
            fsr_q <= result;
          if (wr_f & int_st)
            st_q <= result;
          if (z_aff)
            st_q[`RCALU_BIT_Z] <= rcalu_zero(alu[7:0]);
          if (c_aff)
            st_q[`RCALU_BIT_C] <= alu[9];
          if (dc_aff)
            st_q[`RCALU_BIT_DC] <= alu[8];
          if (is_call) begin
            stk1_q <= stk0_q;
            stk0_q <= pc_q;
            pc_q <= tgt_call[PC_W-1:0];
          end else if (is_retlw) begin
            pc_q <= stk0_q;
            stk0_q <= stk1_q;
          end else if (is_goto) begin
            pc_q <= tgt_goto[PC_W-1:0];
          end else if (pcl_wr) begin
            pc_q <= tgt_pcl[PC_W-1:0];
          end
          if (branch) begin
            flush_q <= 1'b1;
            hold_q <= 1'b1;
          end else if (skip) begin
            flush_q <= 1'b1;
          end
        end
        default: begin
          phase_q <= `RCALU_PH_ONE;
        end
      endcase
    end
  end

  assign pm_addr_o = pc_q;
  assign rf_addr_o = addr_q;
  assign rf_rd_o = master_clear_n_f_q & ph_two & ext;
  assign rf_wr_o = master_clear_n_f_q & ph_four & wr_f & ext;
  assign rf_wdata_o = wdata_q;
  assign acc_o = w_q;
  assign status_o = st_q;
  assign phase_o = phase_q;
  assign quarter_rate_clock_out_o = quarter_rate_clock_out_q;

endmodule // rcalu_core

`default_nettype wire

//--- sim/rcalu_core_asserts.sv
/* port checker for the core.
   bound into rcalu_core by the bench top. */
`timescale 1ns/1ps
`default_nettype none
module rcalu_core_asserts #(
  parameter PC_W = 11
) (
  input wire logic clock_i, // clock
  input wire logic rst_i, // async reset
  input wire logic master_clear_n_i, // clear pin
  input wire logic rc_mode_i, // rc config
  input wire logic [PC_W-1:0] pm_addr_o, // fetch address
  input wire logic [4:0] rf_addr_o, // file address
  input wire logic rf_rd_o, // read strobe
  input wire logic rf_wr_o, // write strobe
  input wire logic [7:0] acc_o, // accumulator
  input wire logic [7:0] status_o, // status
  input wire logic [3:0] phase_o, // phase
  input wire logic quarter_rate_clock_out_o // clock out
);
  logic [3:0] mc_q;
  // let the clear filter drain before checks resume
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) mc_q <= 4'h0;
    else mc_q <= {mc_q[2:0], master_clear_n_i};
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i || mc_q != 4'hf || !master_clear_n_i);
  property p_phase_ring;
    phase_o == 4'h1 |=> phase_o == 4'h2 ##1 phase_o == 4'h4 ##1 phase_o == 4'h8 ##1 phase_o == 4'h1;
  endproperty
  a_phase_ring: assert property (p_phase_ring) else $error("phase order broken");
  property p_qclk;
    $stable(rc_mode_i) |-> quarter_rate_clock_out_o == (rc_mode_i && (phase_o[2] || phase_o[3]));
  endproperty
  a_qclk: assert property (p_qclk) else $error("clock out wrong");
  property p_rd_phase;
    rf_rd_o |-> phase_o == 4'h2;
  endproperty
  a_rd_phase: assert property (p_rd_phase) else $error("read off phase two");
  property p_wr_addr;
    rf_wr_o |-> phase_o == 4'h8 && rf_addr_o == $past(rf_addr_o, 2);
  endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write phase or address wrong");
  property p_pc_stand;
    (phase_o == 4'h2 || phase_o == 4'h4) |=> $stable(pm_addr_o);
  endproperty
  a_pc_stand: assert property (p_pc_stand) else $error("fetch address moved");
  property p_refused;
    (rf_rd_o || rf_wr_o) |-> !(rf_addr_o inside {5'h02, 5'h03, 5'h04});
  endproperty
  a_refused: assert property (p_refused) else $error("core register strobed out");
  property p_reset_top;
    disable iff (1'b0) $fell(rst_i) |-> pm_addr_o == {PC_W{1'b1}} && acc_o == 8'h00 && status_o == 8'h18;
  endproperty
  a_reset_top: assert property (p_reset_top) else $error("reset state wrong");
  property p_mc_reset;
    disable iff (rst_i) !master_clear_n_i [*6] |-> pm_addr_o == {PC_W{1'b1}} && phase_o == 4'h1;
  endproperty
  a_mc_reset: assert property (p_mc_reset) else $error("clear did not reset");
endmodule // rcalu_core_asserts
`default_nettype wire

//--- sim/rcalu_mem_model.sv
/* program memory and register file beside the core.
   answers both buses combinationally; writes on the rising edge. */
`timescale 1ns/1ps
`default_nettype none
module rcalu_mem_model (
  input wire logic clock_i, // clock
  input wire logic [10:0] pm_addr_i, // fetch address
  output logic [11:0] pm_data_o, // instruction word
  input wire logic [4:0] rf_addr_i, // file address
  input wire logic rf_rd_i, // read strobe
  output logic [7:0] rf_rdata_o, // read data
  input wire logic rf_wr_i, // write strobe
  input wire logic [7:0] rf_wdata_i // write data
);
  logic [11:0] pm [0:2047];
  logic [7:0] rf [0:31];
  assign pm_data_o = pm[pm_addr_i];
  // unselected read bus shows the inverse
  assign rf_rdata_o = rf_rd_i ? rf[rf_addr_i] : ~rf[rf_addr_i];
  always @(posedge clock_i) begin
    if (rf_wr_i) begin
      rf[rf_addr_i] <= rf_wdata_i;
    end
  end
endmodule // rcalu_mem_model
`default_nettype wire

//--- sim/tb_risc_core_alu_pipeline.sv
/* self-checking bench: core plus memory model running a short program.
   expects the checker and model files compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_risc_core_alu_pipeline;
  localparam logic [11:0] PROG [0:7] = '{12'hc0f, 12'h030, 12'h1d1, 12'hc05, 12'h092, 12'h033, 12'h920, 12'ha07};
  // pointer, indirect write, rotate, bit tests with skip, bit set, move, literal xor
  localparam logic [11:0] OPS [0:11] = '{12'hc14, 12'h024, 12'hc81, 12'h020, 12'h374, 12'h634,
    12'h734, 12'hcee, 12'h5f4, 12'h214, 12'hf82, 12'ha0b};
  logic clock_i, rst_i, master_clear_n_i, rc_mode_i, rf_rd_o, rf_wr_o, quarter_rate_clock_out_o;
  logic [10:0] pm_addr_o;
  logic [11:0] pm_data_i;
  logic [4:0] rf_addr_o;
  logic [7:0] rf_rdata_i, rf_wdata_o, acc_o, status_o;
  logic [3:0] phase_o;
  integer n_fail = 0, compares = 0, cyc, i;
  rcalu_core u_dut (.clock_i, .rst_i, .master_clear_n_i, .rc_mode_i, .pm_addr_o, .pm_data_i, .rf_addr_o,
    .rf_rd_o, .rf_rdata_i, .rf_wr_o, .rf_wdata_o, .acc_o, .status_o, .phase_o, .quarter_rate_clock_out_o);
  rcalu_mem_model u_mem (.clock_i, .pm_addr_i(pm_addr_o), .pm_data_o(pm_data_i), .rf_addr_i(rf_addr_o),
    .rf_rd_i(rf_rd_o), .rf_rdata_o(rf_rdata_i), .rf_wr_i(rf_wr_o), .rf_wdata_i(rf_wdata_o));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge clock_i);
    #2;
  endtask
  task automatic wait_pc(input logic [10:0] a);
    cyc = 0;
    do begin
      step();
      cyc++;
    end while (pm_addr_o !== a && cyc < 400);
    if (pm_addr_o !== a) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic t_prog;
    wait_pc(11'h000);
    check(16'(cyc), 16'h0005);
    wait_pc(11'h004);
    check({acc_o, status_o}, 16'h001f);
    check(16'(u_mem.rf[5'h10]), 16'h000f);
    wait_pc(11'h006);
    check({acc_o, status_o}, 16'hfe18);
    wait_pc(11'h007);
    check(16'(u_mem.rf[5'h13]), 16'h00fe);
    wait_pc(11'h008);
    check({acc_o, 8'(cyc)}, 16'h3320);
    wait_pc(11'h007);
    i = cyc;
    wait_pc(11'h008);
    check(16'(i + cyc), 16'h0008);
  endtask
  task automatic t_master_clear_n;
    master_clear_n_i = 1'b0;
    repeat (8) step();
    check({acc_o, pm_addr_o[7:0]}, 16'h00ff);
    master_clear_n_i = 1'b1;
    wait_pc(11'h000);
    wait_pc(11'h004);
    check({acc_o, status_o}, 16'h001f);
  endtask
  task automatic t_clock;
    for (int r = 0; r < 2; r++) begin
      rc_mode_i = r[0];
      repeat (4) step();
      i = 0;
      repeat (8) begin
        step();
        i += quarter_rate_clock_out_o;
      end
      check(16'(i), 16'(4 * r));
    end
  endtask
  task automatic t_ops;
    master_clear_n_i = 1'b0;
    repeat (8) step();
    for (i = 0; i < 12; i++) u_mem.pm[i] = OPS[i];
    master_clear_n_i = 1'b1;
    wait_pc(11'h005);
    check(16'(u_mem.rf[5'h14]), 16'h0081);
    wait_pc(11'h009);
    check({acc_o, status_o}, 16'h8119);
    check(16'(u_mem.rf[5'h14]), 16'h0002);
    wait_pc(11'h00c);
    check({acc_o, status_o}, 16'h001d);
    check(16'(u_mem.rf[5'h14]), 16'h0082);
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    master_clear_n_i = 1'b1;
    rc_mode_i = 1'b1;
    for (i = 0; i < 2048; i++) u_mem.pm[i] = (i < 8) ? PROG[i] : 12'h000;
    for (i = 0; i < 32; i++) u_mem.rf[i] = 8'h00;
    u_mem.pm[11'h020] = 12'h930;
    u_mem.pm[11'h021] = 12'h833;
    u_mem.pm[11'h030] = 12'h85a;
    u_mem.rf[5'h11] = 8'hf1;
    u_mem.rf[5'h12] = 8'h03;
    repeat (20) step();
    check({5'h00, pm_addr_o}, 16'h07ff);
    check({acc_o, status_o}, 16'h0018);
    rst_i = 1'b0;
    t_prog();
    t_master_clear_n();
    t_clock();
    t_ops();
    tally_and_finish();
  end
endmodule // tb_risc_core_alu_pipeline
bind rcalu_core rcalu_core_asserts #(.PC_W(PC_W)) u_chk (.clock_i, .rst_i, .master_clear_n_i, .rc_mode_i,
  .pm_addr_o, .rf_addr_o, .rf_rd_o, .rf_wr_o, .acc_o, .status_o, .phase_o, .quarter_rate_clock_out_o);
`default_nettype wire
